/* sn_flash_cmd.sv */
`timescale 1ns/1ps
`default_nettype none
module sn_flash_cmd #(
    parameter int STATUS_WRITE_TIME_NS = sn_pkg::STATUS_WRITE_TIME_NS,
    parameter bit QE_FIXED             = 1'b0
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        sw_reset,
    input  wire logic        cs_n,
    input  wire logic        sclk,
    input  wire logic [3:0]  io_in,
    output logic      [3:0]  io_out,
    output logic      [3:0]  io_oe,
    output logic      [23:0] mem_addr,
    input  wire logic [7:0]  mem_rdata,
    output logic      [7:0]  status_one,
    output logic      [7:0]  status_two,
    output logic      [7:0]  status_three,
    output logic             busy
);
    import sn_pkg::*;

    localparam int TW_RAW = STATUS_WRITE_TIME_NS / CLK_PERIOD_NS;
    localparam int TW_CYC = (TW_RAW < 1) ? 1 : TW_RAW;
    localparam logic [7:0] SR2_BOOT = QE_FIXED ? (SR2_RST | SR2_QE) : SR2_RST;
    localparam logic [7:0] QE_KEEP  = QE_FIXED ? SR2_QE : 8'h00;

    // ------------------------------------------------------------
    // pin sampling and edge detection
    // ------------------------------------------------------------
    logic [5:0] pins_s;
    logic       cs_s;
    logic       sck_s;
    logic [3:0] io_s;
    logic       cs_q;
    logic       sck_q;
    logic       cs_rise;
    logic       sck_rise;
    logic       sck_fall;

    sn_sync #(
        .W       (6),
        .RST_VAL (6'h20)
    ) u_sync (
        .clk (clk),
        .rst (rst),
        .d   ({cs_n, sclk, io_in}),
        .q   (pins_s)
    );

    assign cs_s  = pins_s[5];
    assign sck_s = pins_s[4];
    assign io_s  = pins_s[3:0];

    always_ff @(posedge clk) begin
        if (rst) begin
            cs_q  <= 1'b1;
            sck_q <= 1'b0;
        end else begin
            cs_q  <= cs_s;
            sck_q <= sck_s;
        end
    end

    assign cs_rise  = cs_s && !cs_q;
    assign sck_rise = !cs_s && sck_s && !sck_q;
    assign sck_fall = !cs_s && !sck_s && sck_q;

    // ------------------------------------------------------------
    // state declarations
    // ------------------------------------------------------------
    sn_state_e  st_r;
    sn_state_e  dec_st;
    sn_lanes_e  alanes_r;
    sn_lanes_e  olanes_r;
    sn_lanes_e  dec_al;
    sn_lanes_e  dec_ol;
    sn_lanes_e  cur_ol;
    logic [4:0] dec_dum;
    logic       dec_mode;
    logic [7:0] op_r;
    logic [7:0] op_nxt;
    logic [4:0] cnt_r;
    logic [4:0] dummy_r;
    logic       mode_r;
    logic [15:0] swr_r;
    logic [23:0] addr_r;
    logic [23:0] addr_nxt;
    logic [7:0] osh_r;
    logic [3:0] left_r;
    logic [7:0] out_src;
    logic [7:0] out_cur;
    logic [3:0] out_n;
    logic [7:0] vol1_r;
    logic [7:0] vol2_r;
    logic [7:0] vol3_r;
    logic [7:0] nv1_r;
    logic [7:0] nv2_r;
    logic [7:0] nv3_r;
    logic [7:0] sr1_live;
    logic       wel_r;
    logic       vol_en_r;
    logic       qe;
    logic       swr_ok;
    logic       swr_two;
    logic       nv_go;
    logic       wr_done;
    logic [7:0] wr1;
    logic [7:0] wr2;
    logic [7:0] wr3;
    logic [7:0] m1;
    logic [7:0] m2;
    logic [7:0] m3;
    logic [7:0] stick2;

    function automatic logic [4:0] sn_edges(sn_lanes_e ln, logic [4:0] nbits);
        case (ln)
            LN2:     return nbits >> 1;
            LN4:     return nbits >> 2;
            default: return nbits;
        endcase
    endfunction

    function automatic logic [7:0] sn_merge(logic [7:0] old, logic [7:0] wr,
                                            logic [7:0] mask, logic [7:0] stick);
        return ((old & ~mask) | (wr & mask)) | (old & stick);
    endfunction

    assign qe       = vol2_r[1];
    assign sr1_live = {vol1_r[7:2], wel_r, busy};
    assign op_nxt   = {op_r[6:0], io_s[0]};

    // ------------------------------------------------------------
    // opcode decode
    // ------------------------------------------------------------
    always_comb begin
        dec_st   = ST_IGN;
        dec_al   = LN1;
        dec_ol   = LN1;
        dec_dum  = '0;
        dec_mode = 1'b0;
        case (op_nxt)
            OP_WREN, OP_VWREN, OP_WRDI: begin
                dec_st = ST_DONE;
            end
            OP_WSR1, OP_WSR2, OP_WSR3: begin
                if (wel_r || vol_en_r) begin
                    dec_st = ST_SWR;
                end
            end
            OP_RSR1, OP_RSR2, OP_RSR3: begin
                dec_st = ST_SRD;
            end
            OP_READ: begin
                // this die has no multi-line command mode, so standard mode always holds
                dec_st = ST_ADDR;
            end
            OP_FAST: begin
                dec_st  = ST_ADDR;
                dec_dum = DUMMY_LONG;
            end
            OP_DOUT: begin
                dec_st  = ST_ADDR;
                dec_ol  = LN2;
                dec_dum = DUMMY_LONG;
            end
            OP_QOUT: begin
                if (qe) begin
                    dec_st  = ST_ADDR;
                    dec_ol  = LN4;
                    dec_dum = DUMMY_LONG;
                end
            end
            OP_DIO: begin
                dec_st   = ST_ADDR;
                dec_al   = LN2;
                dec_ol   = LN2;
                dec_mode = 1'b1;
                dec_dum  = DUMMY_IO;
            end
            OP_QIO: begin
                if (qe) begin
                    dec_st   = ST_ADDR;
                    dec_al   = LN4;
                    dec_ol   = LN4;
                    dec_mode = 1'b1;
                    dec_dum  = DUMMY_IO;
                end
            end
            default: begin
                dec_st = ST_IGN;
            end
        endcase
        // only status reads get through a running cycle
        if (busy && dec_st != ST_SRD) begin
            dec_st = ST_IGN;
        end
    end

    always_comb begin
        case (alanes_r)
            LN2:     addr_nxt = {addr_r[21:0], io_s[1:0]};
            LN4:     addr_nxt = {addr_r[19:0], io_s[3:0]};
            default: addr_nxt = {addr_r[22:0], io_s[0]};
        endcase
    end

    // ------------------------------------------------------------
    // instruction sequencer, rising clock edges
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst || cs_s) begin
            st_r     <= ST_OP;
            cnt_r    <= '0;
            alanes_r <= LN1;
            olanes_r <= LN1;
            dummy_r  <= '0;
            mode_r   <= 1'b0;
        end else if (sck_rise) begin
            case (st_r)
                ST_OP: begin
                    op_r  <= op_nxt;
                    cnt_r <= cnt_r + 5'h01;
                    if (cnt_r == OP_BITS - 5'h01) begin
                        st_r     <= dec_st;
                        cnt_r    <= '0;
                        alanes_r <= dec_al;
                        olanes_r <= dec_ol;
                        dummy_r  <= dec_dum;
                        mode_r   <= dec_mode;
                    end
                end
                ST_ADDR: begin
                    cnt_r <= cnt_r + 5'h01;
                    if (cnt_r == sn_edges(alanes_r, ADDR_BITS) - 5'h01) begin
                        cnt_r <= '0;
                        if (mode_r) begin
                            st_r <= ST_MODE;
                        end else if (dummy_r != '0) begin
                            st_r <= ST_DUMMY;
                        end else begin
                            st_r <= ST_DATA;
                        end
                    end
                end
                ST_MODE: begin
                    // mode byte is taken but continuous mode is not offered
                    cnt_r <= cnt_r + 5'h01;
                    if (cnt_r == sn_edges(alanes_r, MODE_BITS) - 5'h01) begin
                        cnt_r <= '0;
                        st_r  <= ST_DUMMY;
                    end
                end
                ST_DUMMY: begin
                    cnt_r <= cnt_r + 5'h01;
                    if (cnt_r == dummy_r - 5'h01) begin
                        cnt_r <= '0;
                        st_r  <= ST_DATA;
                    end
                end
                ST_SWR: begin
                    swr_r <= {swr_r[14:0], io_s[0]};
                    if (cnt_r <= SWR_TWO) begin
                        cnt_r <= cnt_r + 5'h01;
                    end
                end
                default: begin
                    st_r <= st_r;
                end
            endcase
        end
    end

    // address register: loaded while shifting, stepped per output byte
    always_ff @(posedge clk) begin
        if (rst) begin
            addr_r <= '0;
        end else if (sck_rise && st_r == ST_ADDR) begin
            addr_r <= addr_nxt;
        end else if (sck_fall && st_r == ST_DATA && left_r == '0) begin
            addr_r <= addr_r + 24'h000001;
        end
    end

    assign mem_addr = addr_r;

    // ------------------------------------------------------------
    // output shifter, falling clock edges
    // ------------------------------------------------------------
    always_comb begin
        case (op_r)
            OP_RSR2: out_src = vol2_r;
            OP_RSR3: out_src = vol3_r;
            default: out_src = sr1_live;
        endcase
        if (st_r == ST_DATA) begin
            out_src = mem_rdata;
        end
        cur_ol  = (st_r == ST_SRD) ? LN1 : olanes_r;
        out_cur = (left_r == '0) ? out_src : osh_r;
        case (cur_ol)
            LN2:     out_n = 4'h2;
            LN4:     out_n = 4'h4;
            default: out_n = 4'h1;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst || cs_s) begin
            io_out <= '0;
            io_oe  <= '0;
            osh_r  <= '0;
            left_r <= '0;
        end else if (sck_fall && (st_r == ST_DATA || st_r == ST_SRD)) begin
            // status byte reloads each time, so it repeats until select rises
            osh_r  <= out_cur << out_n;
            left_r <= ((left_r == '0) ? BYTE_BITS : left_r) - out_n;
            // lines turn around on the first data falling edge only
            case (cur_ol)
                LN2: begin
                    io_out <= {2'b00, out_cur[7:6]};
                    io_oe  <= 4'h3;
                end
                LN4: begin
                    io_out <= out_cur[7:4];
                    io_oe  <= 4'hf;
                end
                default: begin
                    io_out <= {2'b00, out_cur[7], 1'b0};
                    io_oe  <= 4'h2;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // status write merge
    // ------------------------------------------------------------
    assign swr_two = (op_r == OP_WSR1) && (cnt_r == SWR_TWO);
    assign swr_ok  = (st_r == ST_SWR) && ((cnt_r == SWR_ONE) || swr_two);
    assign nv_go   = cs_rise && swr_ok && !vol_en_r && wel_r;

    always_comb begin
        m1     = '0;
        m2     = '0;
        m3     = '0;
        wr1    = swr_two ? swr_r[15:8] : swr_r[7:0];
        wr2    = swr_r[7:0];
        wr3    = swr_r[7:0];
        // a byte after opcode 01h lands in register one only
        if (swr_two) begin
            m1 = SR1_WMASK;
            m2 = SR2_WMASK;
        end else if (op_r == OP_WSR1) begin
            m1 = SR1_WMASK;
        end else if (op_r == OP_WSR2) begin
            m2 = SR2_WMASK;
        end else begin
            m3 = SR3_WMASK;
        end
        m2 = m2 & ~QE_KEEP;
        stick2 = SR2_LB | (vol_en_r ? SR2_SRL : 8'h00);
    end

    // ------------------------------------------------------------
    // status registers, both copies
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            nv1_r    <= SR1_RST;
            nv2_r    <= SR2_BOOT;
            nv3_r    <= SR3_RST;
            vol1_r   <= SR1_RST;
            vol2_r   <= SR2_BOOT;
            vol3_r   <= SR3_RST;
            wel_r    <= 1'b0;
            vol_en_r <= 1'b0;
        end else if (sw_reset) begin
            vol1_r   <= nv1_r;
            vol2_r   <= nv2_r;
            vol3_r   <= nv3_r;
            wel_r    <= 1'b0;
            vol_en_r <= 1'b0;
        end else begin
            if (wr_done) begin
                wel_r <= 1'b0;
            end
            if (cs_rise && st_r == ST_DONE) begin
                case (op_r)
                    OP_WREN:  wel_r    <= 1'b1;
                    OP_WRDI:  wel_r    <= 1'b0;
                    OP_VWREN: vol_en_r <= 1'b1;
                    default:  vol_en_r <= vol_en_r;
                endcase
            end
            if (cs_rise && swr_ok) begin
                // volatile update lands one clock after select rise; busy also starts then unless volatile write enable was set
                vol1_r <= sn_merge(vol1_r, wr1, m1, 8'h00);
                vol2_r <= sn_merge(vol2_r, wr2, m2, stick2) | QE_KEEP;
                vol3_r <= sn_merge(vol3_r, wr3, m3, 8'h00);
                vol_en_r <= 1'b0;
                if (!vol_en_r) begin
                    nv1_r <= sn_merge(nv1_r, wr1, m1, 8'h00);
                    nv2_r <= sn_merge(nv2_r, wr2, m2, SR2_LB) | QE_KEEP;
                    nv3_r <= sn_merge(nv3_r, wr3, m3, 8'h00);
                end
            end
        end
    end

    sn_timer #(
        .CYCLES (TW_CYC)
    ) u_wtimer (
        .clk   (clk),
        .rst   (rst),
        .start (nv_go),
        .busy  (busy),
        .done  (wr_done)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            status_one <= SR1_RST;
        end else begin
            status_one <= sr1_live;
        end
    end

    assign status_two   = vol2_r;
    assign status_three = vol3_r;

endmodule // sn_flash_cmd
`default_nettype wire

/* sn_pkg.sv */
package sn_pkg;

    localparam logic [7:0] OP_WREN  = 8'h06;
    localparam logic [7:0] OP_VWREN = 8'h50;
    localparam logic [7:0] OP_WRDI  = 8'h04;
    localparam logic [7:0] OP_WSR1  = 8'h01;
    localparam logic [7:0] OP_WSR2  = 8'h31;
    localparam logic [7:0] OP_WSR3  = 8'h11;
    localparam logic [7:0] OP_RSR1  = 8'h05;
    localparam logic [7:0] OP_RSR2  = 8'h35;
    localparam logic [7:0] OP_RSR3  = 8'h15;
    localparam logic [7:0] OP_READ  = 8'h03;
    localparam logic [7:0] OP_FAST  = 8'h0b;
    localparam logic [7:0] OP_DOUT  = 8'h3b;
    localparam logic [7:0] OP_QOUT  = 8'h6b;
    localparam logic [7:0] OP_DIO   = 8'hbb;
    localparam logic [7:0] OP_QIO   = 8'heb;

    // status field layout
    localparam int         SR1_BUSY   = 0;
    localparam int         SR1_WEL    = 1;
    localparam logic [7:0] SR1_WMASK  = 8'h7c;
    localparam logic [7:0] SR2_WMASK  = 8'h7b;
    localparam logic [7:0] SR3_WMASK  = 8'h64;
    localparam logic [7:0] SR2_QE     = 8'h02;
    localparam logic [7:0] SR2_SRL    = 8'h01;
    localparam logic [7:0] SR2_LB     = 8'h38;
    localparam logic [7:0] SR1_RST    = 8'h00;
    localparam logic [7:0] SR2_RST    = 8'h00;
    localparam logic [7:0] SR3_RST    = 8'h00;

    // frame lengths in bits and clocks
    localparam logic [4:0] OP_BITS    = 5'h08;
    localparam logic [4:0] ADDR_BITS  = 5'h18;
    localparam logic [4:0] MODE_BITS  = 5'h08;
    localparam logic [4:0] DUMMY_LONG = 5'h08;
    localparam logic [4:0] DUMMY_IO   = 5'h04;
    localparam logic [4:0] SWR_ONE    = 5'h08;
    localparam logic [4:0] SWR_TWO    = 5'h10;
    localparam logic [3:0] BYTE_BITS  = 4'h8;

    localparam int CLK_PERIOD_NS       = 5;
    localparam int STATUS_WRITE_TIME_NS = 1000000;

    typedef enum logic [3:0] {
        ST_OP, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA,
        ST_SRD, ST_SWR, ST_DONE, ST_IGN
    } sn_state_e;

    typedef enum logic [1:0] {LN1, LN2, LN4} sn_lanes_e;

endpackage

/* sn_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module sn_sync #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    // first stage feeds only the second
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // sn_sync
`default_nettype wire

/* sn_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module sn_timer #(
    parameter int CYCLES = 16
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic start,
    output logic      busy,
    output logic      done
);
    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] cnt_r;

    // a start while running is dropped; the cycle is not restarted
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= '0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                cnt_r <= CW'(CYCLES - 1);
                busy  <= 1'b1;
            end else if (busy) begin
                if (cnt_r == '0) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    cnt_r <= cnt_r - 1'b1;
                end
            end
        end
    end
endmodule // sn_timer
`default_nettype wire

/* sn_flash_cmd_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module sn_flash_cmd_monitor
    import sn_pkg::*;
#(
    parameter int STATUS_WRITE_TIME_NS = sn_pkg::STATUS_WRITE_TIME_NS,
    parameter bit QE_FIXED             = 1'b0
) (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       sw_reset,
    input wire logic       cs_n,
    input wire logic [3:0] io_oe,
    input wire logic [7:0] status_one,
    input wire logic [7:0] status_two,
    input wire logic [7:0] status_three,
    input wire logic       busy
);
    localparam int TW = STATUS_WRITE_TIME_NS / CLK_PERIOD_NS;
    logic [31:0] busy_cnt_r;
    // --------------------------------
    // checks
    // --------------------------------
    // cycle too long for a repetition, so count it
    always_ff @(posedge clk) begin
        if (rst)
            busy_cnt_r <= '0;
        else
            busy_cnt_r <= busy ? busy_cnt_r + 32'h1 : 32'h0;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_busy_span: assert property ($fell(busy) |-> busy_cnt_r inside {[TW-1:TW+1]})
        else $error("write cycle length wrong");
    chk_latch_clear: assert property ($fell(busy) |-> ##[0:3] !status_one[SR1_WEL])
        else $error("latch flag kept after cycle");
    chk_lock_keep: assert property ((|($past(status_two) & ~status_two & SR2_LB))
        |-> $past(sw_reset) || $past(sw_reset, 2)) else $error("lock bit cleared");
    chk_srl_keep: assert property (($fell(status_two[0]) && !$past(sw_reset) && !$past(sw_reset, 2))
        |-> ##[0:4] busy) else $error("register lock cleared without write cycle");
    chk_ro_bits: assert property ((status_two & ~SR2_WMASK) == 8'h00
        && (status_three & ~SR3_WMASK) == 8'h00 && !status_one[7]) else $error("read-only status bit set");
    chk_qe_fixed: assert property (QE_FIXED |-> status_two[1]) else $error("fixed quad enable low");
    chk_oe_quiet: assert property ($fell(cs_n) ##1 (io_oe == 4'h0) |-> (io_oe == 4'h0) [*8])
        else $error("output driven during opcode");
    chk_busy_gate: assert property (busy |-> !io_oe[0]) else $error("array read answered while busy");
endmodule // sn_flash_cmd_monitor
bind sn_flash_cmd sn_flash_cmd_monitor #(.STATUS_WRITE_TIME_NS(STATUS_WRITE_TIME_NS), .QE_FIXED(QE_FIXED))
    sn_flash_cmd_monitor_i (.clk(clk), .rst(rst), .sw_reset(sw_reset), .cs_n(cs_n), .io_oe(io_oe),
    .status_one(status_one), .status_two(status_two), .status_three(status_three), .busy(busy));
`default_nettype wire

/* sn_spi_host.sv */
`timescale 1ns/1ps
`default_nettype none
module sn_spi_host (
    output logic            cs_n,
    output logic            sclk,
    output logic      [3:0] io_in,
    input  wire logic [3:0] io_w
);
    initial begin
        cs_n  = 1'b1;
        sclk  = 1'b0;
        io_in = 4'h0;
    end
    // --------------------------------
    // framing
    // --------------------------------
    task automatic start();
        cs_n = 1'b0;
        #16;
    endtask
    task automatic stop();
        #16 cs_n = 1'b1;
        #200;
    endtask
    // released lines toggle so a stale level never reads as data
    task automatic shift(input int n, input int ln, input bit drv, input logic [31:0] v, output logic [31:0] r);
        logic [3:0] nx;
        r = '0;
        for (int i = 0; i < n; i++) begin
            nx = ~io_in;
            if (drv)
                for (int b = 0; b < ln; b++) nx[b] = v[(n-1-i)*ln+b];
            io_in = nx;
            #32;
            r = (r << ln) | (ln == 1 ? {31'h0, io_w[1]} : {28'h0, io_w} & ((32'h1 << ln) - 1));
            sclk = 1'b1;
            #32 sclk = 1'b0;
        end
    endtask
endmodule // sn_spi_host
`default_nettype wire

/* serial_nor_status_write_and_read_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin n_fail++; \
    $display("ERROR %0t got %h exp %h", $time, (a), (e)); end end
module serial_nor_status_write_and_read_test;
    import sn_pkg::*;
    logic        clk, rst, sw_reset, cs_n, sclk, busy;
    logic [3:0]  host_io, io_out, io_oe, io_w;
    logic [23:0] mem_addr;
    logic [7:0]  mem_rdata, status_one, status_two, status_three;
    int          n_fail = 0;
    int          comparisons = 0;
    assign io_w = (io_oe & io_out) | (~io_oe & host_io);
    assign mem_rdata = mem_addr[7:0] ^ 8'h5c;
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    sn_flash_cmd #(.STATUS_WRITE_TIME_NS(8000)) sn_flash_cmd_i (.clk(clk), .rst(rst), .sw_reset(sw_reset),
        .cs_n(cs_n), .sclk(sclk), .io_in(io_w), .io_out(io_out), .io_oe(io_oe), .mem_addr(mem_addr),
        .mem_rdata(mem_rdata), .status_one(status_one), .status_two(status_two), .status_three(status_three),
        .busy(busy));
    sn_spi_host sn_spi_host_i (.cs_n(cs_n), .sclk(sclk), .io_in(host_io), .io_w(io_w));
    // --------------------------------
    // helpers
    // --------------------------------
    task automatic sfr(input logic [7:0] op, input int nb, input logic [15:0] d);
        logic [31:0] r;
        sn_spi_host_i.start();
        sn_spi_host_i.shift(8, 1, 1, {24'h0, op}, r);
        sn_spi_host_i.shift(nb, 1, 1, {16'h0, d}, r);
        sn_spi_host_i.stop();
    endtask
    task automatic rd_op(input logic [7:0] op, input int al, mc, dc, dl, input logic [3:0] oe);
        logic [31:0] r;
        logic [7:0]  a;
        a = op + 8'h1;
        sn_spi_host_i.start();
        sn_spi_host_i.shift(8, 1, 1, {24'h0, op}, r);
        sn_spi_host_i.shift(24 / al, al, 1, {16'h005a, op}, r);
        sn_spi_host_i.shift(mc, al, 1, 32'hf0, r);
        sn_spi_host_i.shift(dc, 4, 0, 32'h0, r);
        sn_spi_host_i.shift(16 / dl, dl, 0, 32'h0, r);
        `CHK(io_oe, oe)
        if (oe != 4'h0) `CHK(r[15:0], {op ^ 8'h5c, a ^ 8'h5c})
        sn_spi_host_i.stop();
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 4000 && busy !== 1'b0; i++) @(negedge clk);
        repeat (4) @(negedge clk);
        `CHK(status_one[1:0], 2'b00)
    endtask
    // --------------------------------
    // scenarios
    // --------------------------------
    task automatic t_nv();
        logic [31:0] r;
        sfr(OP_WSR1, 8, 16'h00ff);
        `CHK(status_one, 8'h00)
        sfr(OP_WREN, 0, 16'h0);
        sfr(OP_WSR1, 12, 16'h0fff);
        `CHK({status_one, status_two, busy}, 17'h00400)
        sfr(OP_WSR1, 16, 16'hffff);
        `CHK({busy, status_two}, 9'h17b)
        rd_op(OP_READ, 1, 0, 0, 1, 4'h0);
        sn_spi_host_i.start();
        sn_spi_host_i.shift(8, 1, 1, {24'h0, OP_RSR1}, r);
        sn_spi_host_i.shift(16, 1, 0, 32'h0, r);
        `CHK(r[15:0], 16'h7f7f)
        sn_spi_host_i.stop();
        wait_idle();
        $display("t_nv done");
    endtask
    task automatic t_vol();
        sfr(OP_VWREN, 0, 16'h0);
        sfr(OP_WSR2, 8, 16'h0000);
        `CHK({status_one, status_two}, 16'h7c39)
        rd_op(OP_QOUT, 1, 0, 8, 4, 4'h0);
        rd_op(OP_QIO, 4, 2, 4, 4, 4'h0);
        sfr(OP_VWREN, 0, 16'h0);
        sfr(OP_WSR3, 8, 16'h00ff);
        `CHK(status_three, 8'h64)
        @(negedge clk) sw_reset = 1'b1;
        @(negedge clk) sw_reset = 1'b0;
        repeat (4) @(negedge clk);
        `CHK({status_two, status_three}, 16'h7b00)
        $display("t_vol done");
    endtask
    task automatic t_reads();
        rd_op(OP_READ, 1, 0, 0, 1, 4'h2);
        rd_op(OP_FAST, 1, 0, 8, 1, 4'h2);
        rd_op(OP_DOUT, 1, 0, 8, 2, 4'h3);
        rd_op(OP_QOUT, 1, 0, 8, 4, 4'hf);
        rd_op(OP_DIO, 2, 4, 4, 2, 4'h3);
        rd_op(OP_QIO, 4, 2, 4, 4, 4'hf);
        sfr(OP_WREN, 0, 16'h0);
        sfr(OP_WSR2, 8, 16'h0000);
        `CHK(status_two, 8'h38)
        wait_idle();
        $display("t_reads done");
    endtask
    task automatic results();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #200000;
        n_fail++;
        results();
    end
    initial begin
        rst = 1'b1;
        sw_reset = 1'b0;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        `CHK({status_one, status_two, status_three, busy}, 25'h0)
        t_nv();
        t_vol();
        t_reads();
        results();
    end
endmodule // serial_nor_status_write_and_read_test
`default_nettype wire
